// ### src/hpd_consts.svh
// Function
// - Own DMA logic moves data between port data register and memory.
// - Ready output held high while internal resources are busy.
// - Access type, direction and halfword ident latched at internal strobe fall.
// - Read fetches from read address register; ready low only when data valid.
// - Host waits for ready low; strobe rise latches bus into port data register.
// - Written data stored by DMA at write address register location.
// - Internal strobe formed from chip select and both data strobes.
// - Ready output driven low whenever chip select is high.
// - Access type 00 control, 01 data increment, 10 address, 11 data.
// - Post-increment data access adds one to the address register afterwards.
// - Data access without increment leaves address registers unchanged.
// - Direction high means read from port, low means write.
// - Single mode address write loads both read and write address registers.
// - Split mode address access reaches read register if select 1, else write.
// - Split mode increments only the register used, after its use.
`ifndef HPD_CONSTS_SVH
`define HPD_CONSTS_SVH

`define HPD_CTRL_ORDER_BIT 0
`define HPD_CTRL_SPLIT_BIT 3
`define HPD_CTRL_SEL_BIT 4
`define HPD_CTRL_ORDER_MIRROR 8
`define HPD_CTRL_RESET 1'b0
`define HPD_ADDR_RESET 32'h00000000
`define HPD_ADDR_STEP 32'h00000001
`define HPD_FIFO_DEPTH 16

`endif

// ### src/hpd_pkg.sv
`default_nettype none
package hpd_pkg;
    typedef enum logic [1:0] {
        HPD_ACC_CTRL = 2'b00,
        HPD_ACC_DATA_INC = 2'b01,
        HPD_ACC_ADDR = 2'b10,
        HPD_ACC_DATA_FIX = 2'b11
    } hpd_access_t;
    typedef enum logic [1:0] {
        HPD_DMA_IDLE = 2'b00,
        HPD_DMA_WRITE = 2'b01,
        HPD_DMA_READ = 2'b10
    } hpd_dma_t;
endpackage : hpd_pkg
`default_nettype wire

// ### src/hpd_fifo.sv
`default_nettype none
module hpd_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    // Depth is expected to be a power of two so the pointers wrap freely.
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign inReady = count_reg != (AW + 1)'(DEPTH);
    assign outValid = count_reg != '0;
    assign outData = store[rdPtr_reg];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + AW'(push);
            rdPtr_reg <= rdPtr_reg + AW'(pop);
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : hpd_fifo
`default_nettype wire

// ### src/hpd_host_port.sv
`include "hpd_consts.svh"
`default_nettype none
module hpd_host_port #(
    parameter int FIFO_DEPTH = `HPD_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic data_strobe_a,
    input wire logic data_strobe_b,
    input wire logic [1:0] access_type,
    input wire logic direction_in,
    input wire logic halfword_ident,
    input wire logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic hostDataOe,
    output logic host_ready_n,
    output logic halfwordOrder,
    output logic splitAddrMode,
    output logic addrRegSelect,
    output logic memReq,
    output logic memWrite,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata,
    input wire logic memAck
);
    // ------------------------------------------------------------
    // Strobe forming and synchronisation
    // ------------------------------------------------------------
    logic strobeActive;
    logic stb1_reg;
    logic stb2_reg;
    logic stb3_reg;
    logic fallEvt;
    logic riseEvt;
    logic [19:0] pipe1_reg;
    logic [19:0] pipe2_reg;
    logic [19:0] pipe3_reg;

    // Active means internal strobe low; covers all strobe wiring options.
    assign strobeActive = ~chip_select_n & (data_strobe_a ^ data_strobe_b);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stb1_reg <= 1'b0;
            stb2_reg <= 1'b0;
            stb3_reg <= 1'b0;
        end else begin
            stb1_reg <= strobeActive;
            stb2_reg <= stb1_reg;
            stb3_reg <= stb2_reg;
        end
    end

    // Pins travel with the strobe so each edge sees the matching sample.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pipe1_reg <= '0;
            pipe2_reg <= '0;
            pipe3_reg <= '0;
        end else begin
            pipe1_reg <= {access_type, direction_in, halfword_ident, hostDataIn};
            pipe2_reg <= pipe1_reg;
            pipe3_reg <= pipe2_reg;
        end
    end

    assign fallEvt = stb2_reg & ~stb3_reg;
    assign riseEvt = ~stb2_reg & stb3_reg;

    // ------------------------------------------------------------
    // Latched cycle type
    // ------------------------------------------------------------
    hpd_pkg::hpd_access_t cycType_reg;
    logic cycRead_reg;
    logic cycHw_reg;
    logic isData;
    logic isInc;
    logic [15:0] dataNow;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cycType_reg <= hpd_pkg::HPD_ACC_CTRL;
            cycRead_reg <= 1'b0;
            cycHw_reg <= 1'b0;
        end else if (fallEvt) begin
            cycType_reg <= hpd_pkg::hpd_access_t'(pipe2_reg[19:18]);
            cycRead_reg <= pipe2_reg[17];
            cycHw_reg <= pipe2_reg[16];
        end
    end

    assign isData = cycType_reg == hpd_pkg::HPD_ACC_DATA_INC ||
        cycType_reg == hpd_pkg::HPD_ACC_DATA_FIX;
    assign isInc = cycType_reg == hpd_pkg::HPD_ACC_DATA_INC;
    assign dataNow = pipe3_reg[15:0];

    // ------------------------------------------------------------
    // Halfword assembly
    // ------------------------------------------------------------
    function automatic logic [15:0] pickHalf(
        input logic [31:0] word,
        input logic order,
        input logic second
    );
        pickHalf = (order ^ second) ? word[15:0] : word[31:16];
    endfunction : pickHalf

    logic [15:0] firstHalf_reg;
    logic [31:0] joined;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            firstHalf_reg <= '0;
        end else if (riseEvt && !cycRead_reg && !cycHw_reg) begin
            firstHalf_reg <= dataNow;
        end
    end

    // Order set means the first halfword carries the low bits.
    assign joined = halfwordOrder ? {dataNow, firstHalf_reg} : {firstHalf_reg, dataNow};

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [15:0] ctrlView;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            halfwordOrder <= `HPD_CTRL_RESET;
            splitAddrMode <= `HPD_CTRL_RESET;
            addrRegSelect <= `HPD_CTRL_RESET;
        end else if (riseEvt && !cycRead_reg && cycType_reg == hpd_pkg::HPD_ACC_CTRL) begin
            halfwordOrder <= dataNow[`HPD_CTRL_ORDER_BIT];
            splitAddrMode <= dataNow[`HPD_CTRL_SPLIT_BIT];
            addrRegSelect <= dataNow[`HPD_CTRL_SEL_BIT];
        end
    end

    always_comb begin
        ctrlView = '0;
        ctrlView[`HPD_CTRL_ORDER_BIT] = halfwordOrder;
        ctrlView[`HPD_CTRL_ORDER_MIRROR] = halfwordOrder;
        ctrlView[`HPD_CTRL_SPLIT_BIT] = splitAddrMode;
        ctrlView[`HPD_CTRL_SEL_BIT] = addrRegSelect;
    end

    // ------------------------------------------------------------
    // Address registers
    // ------------------------------------------------------------
    logic [31:0] read_addr_reg;
    logic [31:0] write_addr_reg;
    logic secondRise;
    logic addrLoad;
    logic incRead;
    logic incWrite;

    assign secondRise = riseEvt & cycHw_reg;
    assign addrLoad = secondRise & ~cycRead_reg & cycType_reg == hpd_pkg::HPD_ACC_ADDR;
    // Only the post-increment type moves an address, after its last halfword.
    assign incRead = secondRise & isInc & (cycRead_reg | ~splitAddrMode);
    assign incWrite = secondRise & isInc & (~cycRead_reg | ~splitAddrMode);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            read_addr_reg <= `HPD_ADDR_RESET;
        end else if (addrLoad && (!splitAddrMode || addrRegSelect)) begin
            read_addr_reg <= joined;
        end else if (incRead) begin
            read_addr_reg <= read_addr_reg + `HPD_ADDR_STEP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            write_addr_reg <= `HPD_ADDR_RESET;
        end else if (addrLoad && (!splitAddrMode || !addrRegSelect)) begin
            write_addr_reg <= joined;
        end else if (incWrite) begin
            write_addr_reg <= write_addr_reg + `HPD_ADDR_STEP;
        end
    end

    // ------------------------------------------------------------
    // Write path buffer
    // ------------------------------------------------------------
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic [63:0] fifoOutData;
    logic fifoOutReady;

    // A push refused while full is lost, as the host broke the handshake.
    assign fifoInValid = secondRise & ~cycRead_reg & isData;

    hpd_fifo #(
        .WIDTH(64),
        .DEPTH(FIFO_DEPTH)
    ) writeFifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .inValid(fifoInValid),
        .inData({write_addr_reg, joined}),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoOutReady)
    );

    // ------------------------------------------------------------
    // DMA engine
    // ------------------------------------------------------------
    hpd_pkg::hpd_dma_t dmaState_reg;
    logic rdPending_reg;
    logic rdDone;
    logic [31:0] port_data_reg;

    assign fifoOutReady = dmaState_reg == hpd_pkg::HPD_DMA_IDLE;
    assign rdDone = dmaState_reg == hpd_pkg::HPD_DMA_READ && memAck;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dmaState_reg <= hpd_pkg::HPD_DMA_IDLE;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= '0;
            memWdata <= '0;
        end else begin
            unique case (dmaState_reg)
                hpd_pkg::HPD_DMA_IDLE: begin
                    // Pending writes drain first so a read sees them.
                    if (fifoOutValid) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memAddr <= fifoOutData[63:32];
                        memWdata <= fifoOutData[31:0];
                        dmaState_reg <= hpd_pkg::HPD_DMA_WRITE;
                    end else if (rdPending_reg) begin
                        memReq <= 1'b1;
                        memWrite <= 1'b0;
                        memAddr <= read_addr_reg;
                        dmaState_reg <= hpd_pkg::HPD_DMA_READ;
                    end
                end
                hpd_pkg::HPD_DMA_WRITE, hpd_pkg::HPD_DMA_READ: begin
                    if (memAck) begin
                        memReq <= 1'b0;
                        memWrite <= 1'b0;
                        dmaState_reg <= hpd_pkg::HPD_DMA_IDLE;
                    end
                end
                default: begin
                    memReq <= 1'b0;
                    memWrite <= 1'b0;
                    dmaState_reg <= hpd_pkg::HPD_DMA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdPending_reg <= 1'b0;
        end else if (fallEvt && pipe2_reg[17] && !pipe2_reg[16] && pipe2_reg[18]) begin
            // Types 01 and 11 both have the low type bit set.
            rdPending_reg <= 1'b1;
        end else if (rdDone) begin
            rdPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port_data_reg <= '0;
        end else if (rdDone) begin
            port_data_reg <= memRdata;
        end else if (fifoInValid) begin
            port_data_reg <= joined;
        end
    end

    // ------------------------------------------------------------
    // Ready handshake
    // ------------------------------------------------------------
    logic busy_reg;
    logic busyNext;
    logic fallRead;
    logic fallData;

    assign fallRead = pipe2_reg[17];
    assign fallData = pipe2_reg[18];

    always_comb begin
        busyNext = busy_reg;
        if (fallEvt) begin
            if (fallData && fallRead && !pipe2_reg[16]) begin
                busyNext = 1'b1;
            end else if (fallData && !fallRead && pipe2_reg[16]) begin
                busyNext = ~fifoInReady;
            end else begin
                busyNext = 1'b0;
            end
        end else if (busy_reg) begin
            // A read stays busy one edge past the fetch so the bus word is already current.
            busyNext = cycRead_reg ? rdPending_reg : ~fifoInReady;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_reg <= 1'b0;
            host_ready_n <= 1'b0;
        end else begin
            busy_reg <= busyNext;
            host_ready_n <= ~chip_select_n & busyNext;
        end
    end

    // ------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------
    logic [31:0] addrView;
    logic [15:0] readHalf;

    assign addrView = (splitAddrMode && !addrRegSelect) ? write_addr_reg : read_addr_reg;

    always_comb begin
        unique case (cycType_reg)
            hpd_pkg::HPD_ACC_CTRL: readHalf = ctrlView;
            hpd_pkg::HPD_ACC_ADDR: readHalf = pickHalf(addrView, halfwordOrder, cycHw_reg);
            hpd_pkg::HPD_ACC_DATA_INC, hpd_pkg::HPD_ACC_DATA_FIX: begin
                readHalf = pickHalf(port_data_reg, halfwordOrder, cycHw_reg);
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hostDataOut <= '0;
            hostDataOe <= 1'b0;
        end else begin
            hostDataOut <= readHalf;
            // Data strobes act as output enables during reads.
            hostDataOe <= strobeActive & direction_in;
        end
    end
endmodule : hpd_host_port
`default_nettype wire

// ### testbench/hpd_host_port_props.sv
`default_nettype none
module hpd_host_port_props #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic direction_in,
    input wire logic hostDataOe,
    input wire logic host_ready_n,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    input wire logic memAck
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    sequence s_deselected;
        chip_select_n [*5];
    endsequence
    sequence s_pending;
        memReq && !memAck;
    endsequence
    AST_REQ_HOLD: assert property (s_pending |=> memReq)
        else $error("memory request dropped before acknowledge");
    AST_REQ_STABLE: assert property (s_pending |=> $stable({memAddr, memWdata, memWrite}))
        else $error("memory request changed while pending");
    AST_ACK_DROP: assert property (memReq && memAck |=> !memReq)
        else $error("memory request held after acknowledge");
    AST_RDY_DESEL: assert property (chip_select_n |=> !host_ready_n)
        else $error("ready high while deselected");
    AST_RDY_RAISE: assert property ($rose(host_ready_n) |-> !$past(chip_select_n))
        else $error("ready raised without chip select");
    AST_READ_BUSY: assert property (memReq && !memWrite && !chip_select_n
        && !$past(chip_select_n) |-> host_ready_n)
        else $error("ready low before read data fetched");
    AST_OE_DIR: assert property (hostDataOe |-> $past(direction_in))
        else $error("bus driven during a write");
    AST_OE_DESEL: assert property (s_deselected |-> !hostDataOe)
        else $error("bus driven while deselected");
endmodule : hpd_host_port_props

bind hpd_host_port hpd_host_port_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (
    .sys_clk(sys_clk),
    .reset(reset),
    .chip_select_n(chip_select_n),
    .direction_in(direction_in),
    .hostDataOe(hostDataOe),
    .host_ready_n(host_ready_n),
    .memReq(memReq),
    .memWrite(memWrite),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memAck(memAck)
);
`default_nettype wire

// ### testbench/hpd_host_model.sv
`default_nettype none
module hpd_host_model (
    input wire logic sys_clk,
    input wire logic host_ready_n,
    input wire logic [15:0] hostDataOut,
    output logic chip_select_n,
    output logic data_strobe_a,
    output logic data_strobe_b,
    output logic [1:0] access_type,
    output logic direction_in,
    output logic halfword_ident,
    output logic [15:0] hostDataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_select_n = 1'b1;
        data_strobe_a = 1'b1;
        data_strobe_b = 1'b1;
        access_type = 2'h0;
        direction_in = 1'b0;
        halfword_ident = 1'b0;
        hostDataIn = 16'h0000;
    end
    // One halfword; wir[0] picks the moving strobe, wir[1] the idle level of both.
    task automatic xfer(input logic csn, input logic [1:0] t, input logic d, input logic hw,
                        input logic [1:0] wir, input logic [15:0] wd,
                        output logic [15:0] rd, output bit ok, output bit busy);
        @(negedge sys_clk);
        chip_select_n = csn;
        access_type = t;
        direction_in = d;
        halfword_ident = hw;
        hostDataIn = wd;
        data_strobe_a = wir[1] ^ wir[0];
        data_strobe_b = wir[1] ^ ~wir[0];
        ok = 1'b0;
        busy = 1'b0;
        for (int n = 0; n < 600 && !ok; n++) begin
            @(negedge sys_clk);
            if (host_ready_n === 1'b1) busy = 1'b1;
            else if (n >= 5 && host_ready_n === 1'b0) ok = 1'b1;
        end
        rd = hostDataOut;
        data_strobe_a = wir[1];
        data_strobe_b = wir[1];
        hostDataIn = ~wd;
        repeat (6) @(negedge sys_clk);
    endtask : xfer
endmodule : hpd_host_model
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] CTRL = hpd_pkg::HPD_ACC_CTRL;
    localparam logic [1:0] DINC = hpd_pkg::HPD_ACC_DATA_INC;
    localparam logic [1:0] ADDR = hpd_pkg::HPD_ACC_ADDR;
    localparam logic [1:0] DFIX = hpd_pkg::HPD_ACC_DATA_FIX;
    logic sys_clk, reset, chip_select_n, data_strobe_a, data_strobe_b, direction_in;
    logic halfword_ident, hostDataOe, host_ready_n, halfwordOrder, splitAddrMode;
    logic addrRegSelect, memReq, memWrite;
    logic memAck = 1'b0;
    logic [1:0] access_type;
    logic [15:0] hostDataIn, hostDataOut, h;
    logic [31:0] memAddr, memWdata, rdAddr, wrAddr, v, r;
    logic [31:0] memRdata = 32'h0;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] expMem [logic [31:0]];
    int failures, numChecks, memLat, memWait, ackCount;
    int seed = 32'h8BEC;
    bit order, split, sel, b, k, anyBusy;

    hpd_host_port i_dut (.sys_clk, .reset, .chip_select_n, .data_strobe_a, .data_strobe_b,
        .access_type, .direction_in, .halfword_ident, .hostDataIn, .hostDataOut, .hostDataOe,
        .host_ready_n, .halfwordOrder, .splitAddrMode, .addrRegSelect, .memReq, .memWrite,
        .memAddr, .memWdata, .memRdata, .memAck);
    hpd_host_model i_host (.sys_clk, .host_ready_n, .hostDataOut, .chip_select_n,
        .data_strobe_a, .data_strobe_b, .access_type, .direction_in, .halfword_ident,
        .hostDataIn);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Memory responder: read data toggles whenever no answer stands.
    // ------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (memReq && !memAck && memWait >= memLat) begin
            if (memWrite) mem[memAddr] = memWdata;
            memRdata = mem.exists(memAddr) ? mem[memAddr] : memAddr ^ 32'h5A5A0000;
            memAck = 1'b1;
            memWait = 0;
            ackCount++;
        end else begin
            if (memReq && !memAck) memWait++;
            memRdata = ~memRdata;
            memAck = 1'b0;
        end
    end

    task automatic test_done();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic acc(input logic [1:0] t, input logic d, input logic [31:0] w);
        logic [15:0] h0, h1;
        bit k0, k1, b1;
        i_host.xfer(1'b0, t, d, 1'b0, 2'($random(seed)), order ? w[15:0] : w[31:16], h0, k0, b);
        i_host.xfer(1'b0, t, d, 1'b1, 2'($random(seed)), order ? w[31:16] : w[15:0], h1, k1, b1);
        r = order ? {h1, h0} : {h0, h1};
        anyBusy |= b | b1;
        if (!(k0 && k1)) begin
            failures++;
            $display("CHECK FAILED ready expected 0 seen 1");
            test_done();
        end
    endtask : acc

    task automatic ctrl(input bit o, input bit s, input bit l);
        order = o;
        split = s;
        sel = l;
        i_host.xfer(1'b0, CTRL, 1'b0, 1'b0, 2'($random(seed)), {11'h0, l, s, 2'h0, o}, h, k, b);
        i_host.xfer(1'b0, CTRL, 1'b1, 1'b1, 2'($random(seed)), 16'hFFFF, h, k, b);
        check("ctrl read", {o, 3'h0, l, s, 2'h0, o}, {16'h0, h} & 32'h119);
        check("ctrl ports", {o, s, l}, {halfwordOrder, splitAddrMode, addrRegSelect});
    endtask : ctrl

    task automatic wrd(input logic [1:0] t, input logic [31:0] w);
        acc(t, 1'b0, w);
        expMem[wrAddr] = w;
        if (t == DINC) begin
            wrAddr++;
            if (!split) rdAddr++;
        end
    endtask : wrd

    task automatic rdd(input logic [1:0] t);
        acc(t, 1'b1, 32'h0);
        check("read stall", 32'h1, b);
        check("read data", expMem.exists(rdAddr) ? expMem[rdAddr] : rdAddr ^ 32'h5A5A0000, r);
        if (t == DINC) begin
            rdAddr++;
            if (!split) wrAddr++;
        end
    endtask : rdd

    task automatic seta(input logic [31:0] a);
        acc(ADDR, 1'b0, a);
        if (!split || sel) rdAddr = a;
        if (!split || !sel) wrAddr = a;
    endtask : seta

    task automatic geta();
        acc(ADDR, 1'b1, 32'h0);
        check("addr read", (split && !sel) ? wrAddr : rdAddr, r);
        check("addr no stall", 32'h0, b);
    endtask : geta

    initial begin
        reset = 1'b1;
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("after reset", 32'h0, {host_ready_n, hostDataOe, memReq, splitAddrMode});
        ctrl(1'b0, 1'b0, 1'b0);
        seta(32'h100);
        geta();
        for (int i = 0; i < 3; i++) wrd(DINC, $random(seed));
        geta();
        wrd(DFIX, $random(seed));
        wrd(DFIX, $random(seed));
        geta();
        ctrl(1'b1, 1'b0, 1'b0);
        seta(32'h100);
        rdd(DINC);
        rdd(DFIX);
        rdd(DINC);
        geta();
        memLat = 500;
        anyBusy = 1'b0;
        seta(32'h200);
        for (int i = 0; i < 18; i++) wrd(DINC, $random(seed));
        check("fifo full stall", 32'h1, anyBusy);
        memLat = 2;
        ctrl(1'b0, 1'b1, 1'b1);
        seta(32'h300);
        ctrl(1'b0, 1'b1, 1'b0);
        seta(32'h400);
        wrd(DINC, $random(seed));
        rdd(DINC);
        geta();
        ctrl(1'b0, 1'b1, 1'b1);
        geta();
        v = ackCount;
        i_host.xfer(1'b1, DINC, 1'b1, 1'b0, 2'($random(seed)), 16'h1234, h, k, b);
        check("deselected stall", 32'h0, b);
        check("deselected memory", v, ackCount);
        geta();
        foreach (expMem[a]) check("memory", expMem[a], mem.exists(a) ? mem[a] : ~expMem[a]);
        test_done();
    end
endmodule : tb
`default_nettype wire
